// File: logic/vmc_pkg.sv
// Constants, register map and debounce timing for the regulator voltage monitor control
package vmc_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_BUCK   = 7;
    localparam int NUM_LINEAR = 4;
    localparam int NUM_REG    = NUM_BUCK + NUM_LINEAR;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int CNT_W      = 4;
    localparam int DIV_W      = 11;

    typedef logic [NUM_REG-1:0] vmc_reg_vec_t;
    typedef logic [CNT_W-1:0]   vmc_cnt_t;

    // ==========================================================
    // Clock and low-frequency tick
    localparam int CLK_PERIOD_PS  = 8000;
    localparam int TICK_PERIOD_PS = 10000000;
    localparam int DIV_CYCLES     = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);

    // ==========================================================
    // Debounce times, in ns, as printed
    localparam int UV_DB_NS_00 = 5000;
    localparam int UV_DB_NS_01 = 15000;
    localparam int UV_DB_NS_10 = 25000;
    localparam int UV_DB_NS_11 = 40000;
    localparam int OV_DB_NS_00 = 25000;
    localparam int OV_DB_NS_01 = 50000;
    localparam int OV_DB_NS_10 = 80000;
    localparam int OV_DB_NS_11 = 125000;
    localparam int TICK_NS     = TICK_PERIOD_PS / 1000;

    // Least time: round up to whole ticks, never below one
    function automatic vmc_cnt_t vmc_ticks(input int ns);
        int t;
        t = (ns + TICK_NS - 1) / TICK_NS;
        if (t < 1) begin
            t = 1;
        end
        return CNT_W'(t);
    endfunction

    localparam vmc_cnt_t UV_TICKS_00 = vmc_ticks(UV_DB_NS_00);
    localparam vmc_cnt_t UV_TICKS_01 = vmc_ticks(UV_DB_NS_01);
    localparam vmc_cnt_t UV_TICKS_10 = vmc_ticks(UV_DB_NS_10);
    localparam vmc_cnt_t UV_TICKS_11 = vmc_ticks(UV_DB_NS_11);
    localparam vmc_cnt_t OV_TICKS_00 = vmc_ticks(OV_DB_NS_00);
    localparam vmc_cnt_t OV_TICKS_01 = vmc_ticks(OV_DB_NS_01);
    localparam vmc_cnt_t OV_TICKS_10 = vmc_ticks(OV_DB_NS_10);
    localparam vmc_cnt_t OV_TICKS_11 = vmc_ticks(OV_DB_NS_11);

    // ==========================================================
    // Register map, byte addresses
    localparam logic [ADDR_W-1:0] REG_CONFIG     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_MON_ENABLE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_SECURE     = 8'h08;
    localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_INT_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] REG_INT_MASK   = 8'h14;

    // Field positions
    localparam int CFG_UV_LSB = 0;
    localparam int CFG_OV_LSB = 2;
    localparam int SEC_EN_BIT = 0;
    localparam int ST_UV_LSB  = 0;
    localparam int ST_OV_LSB  = 16;

    // Reset values
    localparam logic [1:0]   UV_SEL_RST    = 2'h2;
    localparam logic [1:0]   OV_SEL_RST    = 2'h0;
    localparam vmc_reg_vec_t MON_EN_RST    = '1;
    localparam logic         SECURE_EN_RST = 1'b0;

endpackage

// File: logic/vmc_debounce.sv
// One regulator's comparator debounce and status flag, held until the condition or active drops
`timescale 1ns/10ps
module vmc_debounce
    import vmc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Timing
    input  wire logic             tick,
    input  wire vmc_pkg::vmc_cnt_t limit,
    // Condition
    input  wire logic             cond,
    input  wire logic             active,
    // Result
    output logic                  flag
);

    import vmc_pkg::*;

    typedef struct packed {
        vmc_cnt_t cnt;
        logic     flag;
    } vmc_db_s;

    vmc_db_s st;
    vmc_db_s next_st;

    // ==========================================================
    // Debounce
    always_comb begin
        next_st = st;
        if (!active || !cond) begin
            next_st.cnt  = '0;
            next_st.flag = 1'b0;
        end else if (tick && !st.flag) begin
            if (st.cnt + 1'b1 >= limit) begin
                next_st.flag = 1'b1;
            end else begin
                next_st.cnt = st.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;

    // ==========================================================
    // Checks
    property p_rise_needs_cause;
        @(posedge clk) disable iff (reset)
        $rose(st.flag) |-> $past(cond) && $past(active) && $past(tick);
    endproperty
    a_rise_needs_cause: assert property (p_rise_needs_cause)
        else $error("flag rose without tick and held condition");

    property p_drop_clears;
        @(posedge clk) disable iff (reset)
        !cond |=> !st.flag && st.cnt == '0;
    endproperty
    a_drop_clears: assert property (p_drop_clears)
        else $error("flag or count survived a condition drop");

endmodule

// File: logic/vmc_top.sv
// Regulator undervoltage/overvoltage monitor control with register port and interrupt
//
// Behaviour
// - Undervoltage debounce is picked by a shared two-bit code: 5, 15, 25 or 40 us.
// - A full reset loads the undervoltage debounce code with binary 10.
// - Overvoltage debounce is picked by a shared two-bit code: 25, 50, 80 or 125 us.
// - A full reset loads the overvoltage debounce code with binary 00.
// - Each regulator has a monitor enable bit; its monitor runs only while the bit is 1.
// - All monitor enable bits come out of reset set to 1.
// - With secure access on, monitor enables change only through a secure write.
// - A newly turned-on regulator has fault detection held off until it is in regulation.
// - Disabling a monitor forces its undervoltage and overvoltage status to 0.
// - Debounce intervals are timed in ticks of a 100 kHz rate.
`timescale 1ns/10ps
module vmc_top
    import vmc_pkg::*;
(
    // Clock and reset
    input  wire logic                         MCLK,
    input  wire logic                         RESET,
    // Register port
    input  wire logic [vmc_pkg::ADDR_W-1:0]   ADDR,
    input  wire logic [vmc_pkg::DATA_W-1:0]   WR_DATA,
    input  wire logic                         WR_STROBE,
    input  wire logic                         WR_SECURE,
    input  wire logic                         RD_STROBE,
    output logic      [vmc_pkg::DATA_W-1:0]   RD_DATA,
    // Regulator state
    input  wire vmc_pkg::vmc_reg_vec_t        REG_ON,
    input  wire vmc_pkg::vmc_reg_vec_t        REG_IN_REG,
    // Comparators
    input  wire vmc_pkg::vmc_reg_vec_t        UV_CMP,
    input  wire vmc_pkg::vmc_reg_vec_t        OV_CMP,
    // Status and interrupt
    output vmc_pkg::vmc_reg_vec_t             UV_STATUS,
    output vmc_pkg::vmc_reg_vec_t             OV_STATUS,
    output logic                              IRQ
);

    import vmc_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic             tick;
        logic [1:0]       uv_sel;
        logic [1:0]       ov_sel;
        vmc_reg_vec_t     mon_en;
        logic             secure_en;
        vmc_reg_vec_t     prev_on;
        vmc_reg_vec_t     blank;
        vmc_reg_vec_t     prev_uv;
        vmc_reg_vec_t     prev_ov;
        vmc_reg_vec_t     int_uv;
        vmc_reg_vec_t     int_ov;
        vmc_reg_vec_t     mask_uv;
        vmc_reg_vec_t     mask_ov;
        logic [DATA_W-1:0] rd_data;
        logic             irq;
    } vmc_state_s;

    vmc_state_s st;
    vmc_state_s next_st;

    vmc_cnt_t     uv_limit;
    vmc_cnt_t     ov_limit;
    vmc_reg_vec_t active;
    vmc_reg_vec_t uv_flag;
    vmc_reg_vec_t ov_flag;
    logic         wr_hit_en;

    // ==========================================================
    // Helpers
    function automatic vmc_cnt_t uv_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0: return UV_TICKS_00;
            2'h1: return UV_TICKS_01;
            2'h2: return UV_TICKS_10;
            2'h3: return UV_TICKS_11;
        endcase
    endfunction

    function automatic vmc_cnt_t ov_ticks(input logic [1:0] sel);
        unique case (sel)
            2'h0: return OV_TICKS_00;
            2'h1: return OV_TICKS_01;
            2'h2: return OV_TICKS_10;
            2'h3: return OV_TICKS_11;
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] pair_word(input vmc_reg_vec_t uv,
                                                     input vmc_reg_vec_t ov);
        logic [DATA_W-1:0] w;
        w = '0;
        w[ST_UV_LSB +: NUM_REG] = uv;
        w[ST_OV_LSB +: NUM_REG] = ov;
        return w;
    endfunction

    assign uv_limit = uv_ticks(st.uv_sel);
    assign ov_limit = ov_ticks(st.ov_sel);

    // blanking holds off detection
    // Turn-on cycle masked too: blank only lands one edge after the rise
    assign active = st.mon_en & REG_ON & st.prev_on & ~st.blank;

    assign wr_hit_en = WR_STROBE && ADDR == REG_MON_ENABLE;

    // ==========================================================
    // Per-regulator debounce
    for (genvar i = 0; i < NUM_REG; i++) begin : g_mon
        vmc_debounce u_uv (
            .clk    (MCLK),
            .reset  (RESET),
            .tick   (st.tick),
            .limit  (uv_limit),
            .cond   (UV_CMP[i]),
            .active (active[i]),
            .flag   (uv_flag[i])
        );
        vmc_debounce u_ov (
            .clk    (MCLK),
            .reset  (RESET),
            .tick   (st.tick),
            .limit  (ov_limit),
            .cond   (OV_CMP[i]),
            .active (active[i]),
            .flag   (ov_flag[i])
        );
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;

        next_st.tick = 1'b0;
        if (st.div == DIV_LAST) begin
            next_st.div  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 1'b1;
        end

        next_st.prev_on = REG_ON;
        next_st.blank   = (st.blank & REG_ON & ~REG_IN_REG) | (REG_ON & ~st.prev_on);

        // Register writes
        if (WR_STROBE) begin
            unique case (ADDR)
                REG_CONFIG: begin
                    next_st.uv_sel = WR_DATA[CFG_UV_LSB +: 2];
                    next_st.ov_sel = WR_DATA[CFG_OV_LSB +: 2];
                end
                REG_MON_ENABLE: begin
                    if (!st.secure_en || WR_SECURE) begin
                        next_st.mon_en = WR_DATA[NUM_REG-1:0];
                    end
                end
                REG_SECURE: begin
                    next_st.secure_en = WR_DATA[SEC_EN_BIT];
                end
                REG_INT_MASK: begin
                    next_st.mask_uv = WR_DATA[ST_UV_LSB +: NUM_REG];
                    next_st.mask_ov = WR_DATA[ST_OV_LSB +: NUM_REG];
                end
                default: begin
                end
            endcase
        end

        // Read data valid the cycle after the strobe only
        next_st.rd_data = '0;
        if (RD_STROBE) begin
            unique case (ADDR)
                REG_CONFIG: begin
                    next_st.rd_data[CFG_UV_LSB +: 2] = st.uv_sel;
                    next_st.rd_data[CFG_OV_LSB +: 2] = st.ov_sel;
                end
                REG_MON_ENABLE: next_st.rd_data[NUM_REG-1:0] = st.mon_en;
                REG_SECURE:     next_st.rd_data[SEC_EN_BIT] = st.secure_en;
                REG_STATUS:     next_st.rd_data = pair_word(uv_flag, ov_flag);
                REG_INT_STATUS: next_st.rd_data = pair_word(st.int_uv, st.int_ov);
                REG_INT_MASK:   next_st.rd_data = pair_word(st.mask_uv, st.mask_ov);
                default:        next_st.rd_data = '0;
            endcase
        end

        // Sticky events; read clears, a new event in the same cycle wins
        next_st.prev_uv = uv_flag;
        next_st.prev_ov = ov_flag;
        if (RD_STROBE && ADDR == REG_INT_STATUS) begin
            next_st.int_uv = '0;
            next_st.int_ov = '0;
        end
        next_st.int_uv = next_st.int_uv | (uv_flag & ~st.prev_uv);
        next_st.int_ov = next_st.int_ov | (ov_flag & ~st.prev_ov);

        next_st.irq = |((next_st.int_uv & next_st.mask_uv) |
                        (next_st.int_ov & next_st.mask_ov));
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            st           <= '0;
            st.uv_sel    <= UV_SEL_RST;
            st.ov_sel    <= OV_SEL_RST;
            st.mon_en    <= MON_EN_RST;
            st.secure_en <= SECURE_EN_RST;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    // disabled monitor reads zero
    assign UV_STATUS = uv_flag;
    assign OV_STATUS = ov_flag;
    assign RD_DATA   = st.rd_data;
    assign IRQ       = st.irq;

    // ==========================================================
    // Checks
    property p_uv_default;
        @(posedge MCLK) $fell(RESET) |-> st.uv_sel == UV_SEL_RST;
    endproperty
    a_uv_default: assert property (p_uv_default)
        else $error("undervoltage code not 10 after reset");

    property p_ov_default;
        @(posedge MCLK) $fell(RESET) |-> st.ov_sel == OV_SEL_RST;
    endproperty
    a_ov_default: assert property (p_ov_default)
        else $error("overvoltage code not 00 after reset");

    property p_en_default;
        @(posedge MCLK) $fell(RESET) |-> st.mon_en == MON_EN_RST;
    endproperty
    a_en_default: assert property (p_en_default)
        else $error("monitor enables not all set after reset");

    property p_uv_limit;
        @(posedge MCLK) disable iff (RESET)
        (st.uv_sel == 2'h0 |-> uv_limit == 4'h1) and
        (st.uv_sel == 2'h1 |-> uv_limit == 4'h2) and
        (st.uv_sel == 2'h2 |-> uv_limit == 4'h3) and
        (st.uv_sel == 2'h3 |-> uv_limit == 4'h4);
    endproperty
    a_uv_limit: assert property (p_uv_limit)
        else $error("undervoltage debounce length wrong");

    property p_ov_limit;
        @(posedge MCLK) disable iff (RESET)
        (st.ov_sel == 2'h0 |-> ov_limit == 4'h3) and
        (st.ov_sel == 2'h1 |-> ov_limit == 4'h5) and
        (st.ov_sel == 2'h2 |-> ov_limit == 4'h8) and
        (st.ov_sel == 2'h3 |-> ov_limit == 4'hd);
    endproperty
    a_ov_limit: assert property (p_ov_limit)
        else $error("overvoltage debounce length wrong");

    property p_secure_block;
        @(posedge MCLK) disable iff (RESET)
        wr_hit_en && st.secure_en && !WR_SECURE |=> $stable(st.mon_en);
    endproperty
    a_secure_block: assert property (p_secure_block)
        else $error("monitor enable changed by plain write in secure mode");

    property p_disabled_clear;
        @(posedge MCLK) disable iff (RESET)
        1'b1 |=> ((UV_STATUS | OV_STATUS) & ~$past(st.mon_en)) == '0;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear)
        else $error("status set on a disabled monitor");

    property p_blank_quiet;
        @(posedge MCLK) disable iff (RESET)
        1'b1 |=> ((UV_STATUS | OV_STATUS) & $past(st.blank)) == '0;
    endproperty
    a_blank_quiet: assert property (p_blank_quiet)
        else $error("status set while regulator not yet in regulation");

    property p_turn_on_quiet;
        @(posedge MCLK) disable iff (RESET)
        1'b1 |=> ((UV_STATUS | OV_STATUS) & $past(REG_ON & ~st.prev_on)) == '0;
    endproperty
    a_turn_on_quiet: assert property (p_turn_on_quiet)
        else $error("status set in the cycle a regulator turned on");

    sequence s_tick;
        st.tick;
    endsequence
    sequence s_gap;
        (!st.tick) [*8];
    endsequence
    property p_tick_rate;
        @(posedge MCLK) disable iff (RESET)
        s_tick |=> s_gap;
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("low-frequency tick too close");

endmodule

// File: sim/vmc_cmp_model.sv
// Behavioural regulator outputs and UV/OV comparators seen by the monitor block
`timescale 1ns/10ps
module vmc_cmp_model
    import vmc_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Control from the bench
    input  wire vmc_pkg::vmc_reg_vec_t reg_on,
    input  wire vmc_pkg::vmc_reg_vec_t uv_fault,
    input  wire vmc_pkg::vmc_reg_vec_t ov_fault,
    input  wire logic [15:0]           settle,
    // Analog side
    output vmc_pkg::vmc_reg_vec_t      in_reg,
    output vmc_pkg::vmc_reg_vec_t      uv_cmp,
    output vmc_pkg::vmc_reg_vec_t      ov_cmp
);
    logic [15:0] ramp [NUM_REG];

    // ==========================================================
    // Output ramp; once in regulation it stays so until turned off
    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < NUM_REG; i++) begin
            if (reset || !reg_on[i]) begin
                ramp[i] <= 16'h0;
                in_reg[i] <= 1'b0;
            end else if (ramp[i] < settle) begin
                ramp[i] <= ramp[i] + 16'h1;
            end else begin
                in_reg[i] <= 1'b1;
            end
        end
    end

    // Below target while ramping, so undervoltage shows until in regulation
    assign uv_cmp = uv_fault | (reg_on & ~in_reg);
    assign ov_cmp = ov_fault & reg_on;
endmodule

// File: sim/vmc_top_tb.sv
// Self-checking bench for the regulator voltage monitor control block
`timescale 1ns/10ps
module vmc_top_tb;
    import vmc_pkg::*;
    // ==========================================================
    // Wiring
    logic         MCLK, RESET, WR_STROBE, WR_SECURE, RD_STROBE, IRQ, rd_prev;
    logic [7:0]   ADDR;
    logic [31:0]  WR_DATA, RD_DATA, d;
    logic [15:0]  settle;
    vmc_reg_vec_t REG_ON, REG_IN_REG, UV_CMP, OV_CMP, UV_STATUS, OV_STATUS, uv_f, ov_f;
    logic [31:0]  exp_q [$];
    int           n_errors, cmp_count, seed, idx;
    int           uv_n [4] = '{1, 2, 3, 4};
    int           ov_n [4] = '{3, 5, 8, 13};

    vmc_top DUT (.MCLK(MCLK), .RESET(RESET), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STROBE(WR_STROBE), .WR_SECURE(WR_SECURE), .RD_STROBE(RD_STROBE),
        .RD_DATA(RD_DATA), .REG_ON(REG_ON), .REG_IN_REG(REG_IN_REG), .UV_CMP(UV_CMP),
        .OV_CMP(OV_CMP), .UV_STATUS(UV_STATUS), .OV_STATUS(OV_STATUS), .IRQ(IRQ));

    vmc_cmp_model u_cmp (.clk(MCLK), .reset(RESET), .reg_on(REG_ON), .uv_fault(uv_f),
        .ov_fault(ov_f), .settle(settle), .in_reg(REG_IN_REG), .uv_cmp(UV_CMP),
        .ov_cmp(OV_CMP));

    // ==========================================================
    // Helpers
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Idle cycle after each strobe keeps every strobe a single assignment per step
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic sec);
        ADDR <= a;
        WR_DATA <= dat;
        WR_SECURE <= sec;
        WR_STROBE <= 1'b1;
        @(posedge MCLK);
        WR_STROBE <= 1'b0;
        WR_SECURE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        ADDR <= a;
        RD_STROBE <= 1'b1;
        exp_q.push_back(exp);
        @(posedge MCLK);
        RD_STROBE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic flt(input bit ov, input int i, input logic v);
        if (ov) begin
            ov_f[i] <= v;
        end else begin
            uv_f[i] <= v;
        end
    endtask

    function automatic logic st(input bit ov, input int i);
        return ov ? OV_STATUS[i] : UV_STATUS[i];
    endfunction

    function automatic logic [31:0] bp(input bit ov, input int i);
        return 32'h1 << (i + (ov ? 16 : 0));
    endfunction

    task automatic hold0(input bit ov, input int i, input int cyc);
        repeat (cyc) @(posedge MCLK);
        @(negedge MCLK);
        check("status low", {31'h0, st(ov, i)}, 32'h0);
        @(posedge MCLK);
    endtask

    task automatic wait_st(input bit ov, input int i, input int lim);
        for (int k = 0; k < lim; k++) begin
            @(negedge MCLK);
            if (st(ov, i) === 1'b1) begin
                break;
            end
        end
        check("status high", {31'h0, st(ov, i)}, 32'h1);
        @(posedge MCLK);
    endtask

    // Level output looked at mid-cycle, then back on the rising edge
    task automatic chk_irq(input string what, input logic e);
        @(negedge MCLK);
        check(what, {31'h0, IRQ}, {31'h0, e});
        @(posedge MCLK);
    endtask

    // One debounce pass; glitch drops the condition briefly mid-count
    task automatic db_run(input bit ov, input int code, input bit glitch);
        int n;
        n = ov ? ov_n[code] : uv_n[code];
        idx = $unsigned($random(seed)) % NUM_REG;
        wr(REG_CONFIG, ov ? (32'(code) << 2) : 32'(code), 1'b0);
        wr(REG_INT_MASK, 32'h07ff_07ff, 1'b0);
        flt(ov, idx, 1'b1);
        if (glitch) begin
            repeat (2 * DIV_CYCLES + 600) @(posedge MCLK);
            flt(ov, idx, 1'b0);
            repeat (3) @(posedge MCLK);
            flt(ov, idx, 1'b1);
            hold0(ov, idx, 3 * DIV_CYCLES - 50);
        end else if (n > 1) begin
            hold0(ov, idx, (n - 1) * DIV_CYCLES - 6);
        end
        wait_st(ov, idx, DIV_CYCLES + 100);
        rd(REG_STATUS, bp(ov, idx));
        chk_irq("irq", 1'b1);
        rd(REG_INT_STATUS, bp(ov, idx));
        flt(ov, idx, 1'b0);
        hold0(ov, idx, 2);
        rd(REG_INT_STATUS, 32'h0);
        chk_irq("irq", 1'b0);
        $display("test debounce ov=%0d code=%0d glitch=%0d finished", ov, code, glitch);
    endtask

    // ==========================================================
    // Read data watcher: one note per read, compared in the answer cycle
    always @(posedge MCLK) rd_prev <= RD_STROBE;
    always @(negedge MCLK) begin
        if (rd_prev === 1'b1) begin
            check("RD_DATA", RD_DATA, exp_q.pop_front());
        end
    end

    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    // Longest path is the 13-tick overvoltage pass; whole run is under 70k cycles
    initial begin
        repeat (95000) @(posedge MCLK);
        n_errors++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = 32'h6e8b;
        {RESET, WR_STROBE, WR_SECURE, RD_STROBE} = 4'b1000;
        {ADDR, WR_DATA, uv_f, ov_f} = '0;
        REG_ON = '1;
        settle = 16'h4;
        n_errors = 0;
        cmp_count = 0;
        repeat (12) @(posedge MCLK);
        RESET <= 1'b0;
        repeat (20) @(posedge MCLK);
        rd(REG_CONFIG, 32'h2);
        rd(REG_MON_ENABLE, 32'h7ff);
        rd(REG_SECURE, 32'h0);
        rd(REG_INT_MASK, 32'h0);
        wr(8'h20, 32'hffff_ffff, 1'b0);
        rd(8'h20, 32'h0);
        d = $random(seed);
        wr(REG_CONFIG, d, 1'b0);
        rd(REG_CONFIG, d & 32'hf);
        $display("test reset values finished");
        for (int c = 0; c < 4; c++) db_run(1'b0, c, 1'b0);
        for (int c = 0; c < 4; c++) db_run(1'b1, c, 1'b0);
        db_run(1'b0, 3, 1'b1);
        wr(REG_CONFIG, 32'h0, 1'b0);
        flt(1'b0, idx, 1'b1);
        wait_st(1'b0, idx, DIV_CYCLES + 100);
        wr(REG_MON_ENABLE, 32'h7ff ^ (32'h1 << idx), 1'b0);
        hold0(1'b0, idx, 0);
        hold0(1'b0, idx, 2 * DIV_CYCLES);
        rd(REG_MON_ENABLE, 32'h7ff ^ (32'h1 << idx));
        flt(1'b0, idx, 1'b0);
        wr(REG_MON_ENABLE, 32'h7ff, 1'b0);
        rd(REG_INT_STATUS, bp(1'b0, idx));
        $display("test monitor disable finished");
        wr(REG_SECURE, 32'h1, 1'b0);
        wr(REG_MON_ENABLE, 32'h0, 1'b0);
        rd(REG_MON_ENABLE, 32'h7ff);
        wr(REG_MON_ENABLE, 32'h0aa, 1'b1);
        rd(REG_MON_ENABLE, 32'h0aa);
        wr(REG_MON_ENABLE, 32'h7ff, 1'b1);
        wr(REG_SECURE, 32'h0, 1'b0);
        rd(REG_SECURE, 32'h0);
        $display("test secure write finished");
        wr(REG_INT_MASK, 32'h0, 1'b0);
        settle <= 16'(6 * DIV_CYCLES);
        REG_ON[idx] <= 1'b0;
        repeat (4) @(posedge MCLK);
        REG_ON[idx] <= 1'b1;
        flt(1'b0, idx, 1'b1);
        hold0(1'b0, idx, 6 * DIV_CYCLES - 200);
        wait_st(1'b0, idx, DIV_CYCLES + 400);
        chk_irq("irq masked", 1'b0);
        rd(REG_INT_STATUS, bp(1'b0, idx));
        flt(1'b0, idx, 1'b0);
        settle <= 16'h4;
        hold0(1'b0, idx, 2);
        $display("test turn-on blanking finished");
        wrap_up();
    end
endmodule
